// file: inc/dtef_pkg.sv
package dtef_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clocking and bit cell timing
  localparam int SYS_CLK_MHZ = 250;
  localparam int FM_RATE_KBPS = 250;
  localparam int MFM_RATE_KBPS = 500;
  localparam int FM_HALF_CELL = SYS_CLK_MHZ * 1000 / FM_RATE_KBPS / 2;
  localparam int MFM_HALF_CELL = SYS_CLK_MHZ * 1000 / MFM_RATE_KBPS / 2;
  localparam logic [9:0] FM_HALF_LAST = 10'(FM_HALF_CELL - 1);
  localparam logic [9:0] MFM_HALF_LAST = 10'(MFM_HALF_CELL - 1);
  localparam logic [2:0] LAST_BIT = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // Encoding modes and formatter states
  typedef enum logic [1:0] {
    DTEF_FM = 2'b00,
    DTEF_MFM = 2'b01,
    DTEF_M2FM = 2'b10
  } dtef_mode_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00000, ST_WAIT_IDX = 5'b00001, ST_GAP4A = 5'b00010, ST_SYNC_I = 5'b00011,
    ST_PRE_I = 5'b00100, ST_IAM = 5'b00101, ST_GAP1 = 5'b00110, ST_WAIT_SEC = 5'b00111,
    ST_SYNC_ID = 5'b01000, ST_PRE_ID = 5'b01001, ST_IDAM = 5'b01010, ST_IDB = 5'b01011,
    ST_IDCRC = 5'b01100, ST_GAP2 = 5'b01101, ST_SYNC_D = 5'b01110, ST_PRE_D = 5'b01111,
    ST_DAM = 5'b10000, ST_DATA = 5'b10001, ST_DCRC = 5'b10010, ST_WGOFF = 5'b10011,
    ST_GAP3 = 5'b10100, ST_GAP4B = 5'b10101
  } dtef_state_t;

  typedef struct packed {
    logic [6:0] track;
    logic head;
    logic [5:0] record;
    logic [1:0] len_code;
  } dtef_id_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Field bytes and clock patterns
  localparam logic [7:0] BYTE_SYNC = 8'h00;
  localparam logic [7:0] FILL_FM = 8'hFF;
  localparam logic [7:0] FILL_MFM = 8'h4E;
  localparam logic [7:0] BYTE_C2 = 8'hC2;
  localparam logic [7:0] BYTE_A1 = 8'hA1;
  localparam logic [7:0] CLK_C2 = 8'h14;
  localparam logic [7:0] CLK_A1 = 8'h0A;
  localparam logic [7:0] MARK_INDEX = 8'hFC;
  localparam logic [7:0] MARK_ID = 8'hFE;
  localparam logic [7:0] MARK_DATA = 8'hFB;
  localparam logic [7:0] MARK_DELETED = 8'hF8;
  localparam logic [7:0] CLK_FM_INDEX = 8'hD7;
  localparam logic [7:0] CLK_FM_MARK = 8'hC7;

  ////////////////////////////////////////////////////////////////////////////////
  // Field lengths, as last count value except DATA_BASE in bytes, then start and revolution limits
  localparam logic [10:0] GAP4A_LAST_FM = 11'h027;
  localparam logic [10:0] GAP4A_LAST_MFM = 11'h04F;
  localparam logic [10:0] SYNC_LAST_FM = 11'h005;
  localparam logic [10:0] SYNC_LAST_MFM = 11'h00B;
  localparam logic [10:0] GAP1_LAST_FM = 11'h019;
  localparam logic [10:0] GAP1_LAST_MFM = 11'h031;
  localparam logic [10:0] GAP2_LAST_FM = 11'h00A;
  localparam logic [10:0] GAP2_LAST_MFM = 11'h015;
  localparam logic [10:0] GAP3_LAST_FM = 11'h01A;
  localparam logic [10:0] GAP3_LAST_MFM = 11'h035;
  localparam logic [10:0] PRE_LAST = 11'h002;
  localparam logic [10:0] ID_LAST = 11'h003;
  localparam logic [10:0] CRC_LAST = 11'h001;
  localparam logic [10:0] DATA_BASE = 11'h080;
  localparam logic [6:0] MAX_TRACK = 7'h4C;
  localparam logic [5:0] MAX_HARD_RECORDS = 6'h20;
  localparam logic [3:0] REV_LIMIT = 4'hF;

  ////////////////////////////////////////////////////////////////////////////////
  // CRC, x^16+x^12+x^5+1, preset to all ones
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;

  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ data[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc_byte

endpackage : dtef_pkg

// file: src/dtef_formatter.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Data FIFO between host and serializer
module dtef_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic ready_reg, ready_next, valid_reg, valid_next;
  logic push, pop;

  always_comb begin
    push = in_valid_i & ready_reg;
    pop = out_ready_i & valid_reg;
    wr_ptr_next = push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
    rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
    count_next = (AW+1)'(count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    ready_next = count_next != (AW+1)'(DEPTH);
    valid_next = count_next != '0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
      valid_reg <= valid_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  assign in_ready_o = ready_reg;
  assign out_valid_o = valid_reg;
  assign out_data_o = mem[rd_ptr_reg];
endmodule : dtef_fifo

////////////////////////////////////////////////////////////////////////////////
module dtef_formatter (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire dtef_pkg::dtef_mode_t mode_i,
  input wire logic hard_sector_i,
  input wire logic update_i,
  input wire logic deleted_i,
  input wire logic start_i,
  input wire logic [6:0] track_i,
  input wire logic side_i,
  input wire logic [5:0] rec_count_i,
  input wire logic [1:0] len_code_i,
  input wire logic index_i,
  input wire logic sector_i,
  input wire logic [7:0] din_data_i,
  input wire logic din_valid_i,
  output logic din_ready_o,
  output logic write_data_o,
  output logic write_gate_o,
  output logic side_o,
  output logic busy_o,
  output logic ready_o,
  output logic refused_o,
  output logic underrun_o,
  output logic idle_revs_o
);
  dtef_pkg::dtef_state_t st_reg, st_next;
  dtef_pkg::dtef_mode_t mode_reg, mode_next;
  dtef_pkg::dtef_id_t id_reg, id_next;
  logic [10:0] cnt_reg, cnt_next;
  logic [5:0] recs_reg, recs_next;
  logic [15:0] crc_reg, crc_next;
  logic [3:0] revs_reg, revs_next;
  logic hard_reg, hard_next, upd_reg, upd_next, del_reg, del_next;
  logic gate_reg, gate_next, ready_reg, ready_next, ref_reg, ref_next;
  logic unr_reg, unr_next, idle_reg, idle_next, busy_reg, busy_next;
  logic idx_prev_reg, sec_prev_reg, idx_flag_reg, idx_flag_next, sec_flag_reg, sec_flag_next;
  logic [9:0] div_reg, div_next;
  logic phase_reg, phase_next, pd_reg, pd_next, pc_reg, pc_next, wd_reg, wd_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] cur_byte, clk_pat, fill;
  logic forced, mfm, active, tick, byte_done, dbit, cbit, idx_edge, sec_edge;
  logic [10:0] sync_last, gap_last;
  logic [7:0] fifo_data;
  logic fifo_valid, fifo_pop, bad_start;

  dtef_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .in_data_i(din_data_i),
    .in_valid_i(din_valid_i),
    .in_ready_o(din_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Byte presented to the serializer, held stable for the whole byte unless an empty FIFO fills mid-byte in ST_DATA
  always_comb begin
    mfm = mode_reg != dtef_pkg::DTEF_FM;
    fill = mfm ? dtef_pkg::FILL_MFM : dtef_pkg::FILL_FM;
    sync_last = mfm ? dtef_pkg::SYNC_LAST_MFM : dtef_pkg::SYNC_LAST_FM;
    cur_byte = fill;
    clk_pat = '0;
    forced = 1'b0;
    case (st_reg)
      dtef_pkg::ST_SYNC_I, dtef_pkg::ST_SYNC_ID, dtef_pkg::ST_SYNC_D: cur_byte = dtef_pkg::BYTE_SYNC;
      dtef_pkg::ST_PRE_I: begin
        cur_byte = dtef_pkg::BYTE_C2;
        clk_pat = dtef_pkg::CLK_C2;
        forced = 1'b1;
      end
      dtef_pkg::ST_PRE_ID, dtef_pkg::ST_PRE_D: begin
        cur_byte = dtef_pkg::BYTE_A1;
        clk_pat = dtef_pkg::CLK_A1;
        forced = 1'b1;
      end
      dtef_pkg::ST_IAM: begin
        cur_byte = dtef_pkg::MARK_INDEX;
        clk_pat = dtef_pkg::CLK_FM_INDEX;
        forced = !mfm;
      end
      dtef_pkg::ST_IDAM: begin
        cur_byte = dtef_pkg::MARK_ID;
        clk_pat = dtef_pkg::CLK_FM_MARK;
        forced = !mfm;
      end
      dtef_pkg::ST_DAM: begin
        cur_byte = del_reg ? dtef_pkg::MARK_DELETED : dtef_pkg::MARK_DATA;
        clk_pat = dtef_pkg::CLK_FM_MARK;
        forced = !mfm;
      end
      dtef_pkg::ST_IDB: begin
        case (cnt_reg[1:0])
          2'h0: cur_byte = {1'b0, id_reg.track};
          2'h1: cur_byte = {7'h00, id_reg.head};
          2'h2: cur_byte = {2'h0, id_reg.record};
          default: cur_byte = {6'h00, id_reg.len_code};
        endcase
      end
      dtef_pkg::ST_IDCRC, dtef_pkg::ST_DCRC: cur_byte = cnt_reg[0] ? crc_reg[7:0] : crc_reg[15:8];
      dtef_pkg::ST_DATA: cur_byte = fifo_valid ? fifo_data : dtef_pkg::BYTE_SYNC;
      default: cur_byte = fill;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serializer: clock slot then data slot per cell, MSB first
  always_comb begin
    active = (st_reg != dtef_pkg::ST_IDLE) && (st_reg != dtef_pkg::ST_WAIT_IDX);
    tick = active && (div_reg == (mfm ? dtef_pkg::MFM_HALF_LAST : dtef_pkg::FM_HALF_LAST));
    byte_done = tick && phase_reg && (bit_reg == dtef_pkg::LAST_BIT);
    dbit = cur_byte[3'(dtef_pkg::LAST_BIT - bit_reg)];
    case (mode_reg)
      dtef_pkg::DTEF_FM: cbit = 1'b1;
      dtef_pkg::DTEF_MFM: cbit = !pd_reg && !dbit;
      default: cbit = !pd_reg && !pc_reg && !dbit;
    endcase
    if (forced) begin
      cbit = clk_pat[3'(dtef_pkg::LAST_BIT - bit_reg)];
    end
    div_next = (!active || tick) ? '0 : 10'(div_reg + 1'b1);
    phase_next = active ? (phase_reg ^ tick) : 1'b0;
    bit_next = !active ? '0 : ((tick && phase_reg) ? 3'(bit_reg + 1'b1) : bit_reg);
    pd_next = (tick && phase_reg) ? dbit : pd_reg;
    pc_next = (tick && !phase_reg) ? cbit : pc_reg;
    // No pulse in the cycle the gate falls, so the drive never sees an unguarded transition
    wd_next = tick && gate_reg && gate_next && (phase_reg ? dbit : cbit);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      div_reg <= '0;
      phase_reg <= 1'b0;
      bit_reg <= '0;
      pd_reg <= 1'b0;
      pc_reg <= 1'b0;
      wd_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      phase_reg <= phase_next;
      bit_reg <= bit_next;
      pd_reg <= pd_next;
      pc_reg <= pc_next;
      wd_reg <= wd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Track sequencer
  always_comb begin
    idx_edge = index_i && !idx_prev_reg;
    sec_edge = sector_i && !sec_prev_reg;
    // A zero count means 64 records, more than a hard track holds
    bad_start = (track_i > dtef_pkg::MAX_TRACK) || (hard_sector_i &&
      (rec_count_i > dtef_pkg::MAX_HARD_RECORDS || rec_count_i == '0));
    st_next = st_reg;
    cnt_next = byte_done ? 11'(cnt_reg + 1'b1) : cnt_reg;
    mode_next = mode_reg;
    {id_next, recs_next, hard_next, upd_next, del_next} = {id_reg, recs_reg, hard_reg, upd_reg, del_reg};
    gate_next = gate_reg;
    crc_next = crc_reg;
    ready_next = ready_reg | idx_edge;
    ref_next = ref_reg;
    unr_next = unr_reg;
    idx_flag_next = idx_flag_reg;
    sec_flag_next = sec_flag_reg;
    fifo_pop = 1'b0;
    gap_last = '0;
    revs_next = (st_reg == dtef_pkg::ST_IDLE && idx_edge && revs_reg != dtef_pkg::REV_LIMIT) ? 4'(revs_reg + 1'b1) : revs_reg;
    idle_next = revs_reg == dtef_pkg::REV_LIMIT;
    if (byte_done) begin
      case (st_reg)
        dtef_pkg::ST_SYNC_I, dtef_pkg::ST_SYNC_ID, dtef_pkg::ST_SYNC_D: crc_next = dtef_pkg::CRC_PRESET;
        dtef_pkg::ST_PRE_ID, dtef_pkg::ST_PRE_D, dtef_pkg::ST_IDAM, dtef_pkg::ST_IDB, dtef_pkg::ST_DAM,
        dtef_pkg::ST_DATA: crc_next = dtef_pkg::crc_byte(crc_reg, cur_byte);
        default: crc_next = crc_reg;
      endcase
    end
    case (st_reg)
      dtef_pkg::ST_IDLE: begin
        if (start_i) begin
          ref_next = bad_start;
          revs_next = '0;
          if (!bad_start) begin
            st_next = dtef_pkg::ST_WAIT_IDX;
            mode_next = mode_i;
            hard_next = hard_sector_i;
            upd_next = update_i;
            del_next = deleted_i;
            recs_next = rec_count_i;
            id_next = '{track: track_i, head: side_i, record: '0, len_code: len_code_i};
          end
        end
      end
      dtef_pkg::ST_WAIT_IDX: begin
        cnt_next = '0;
        if (idx_edge) begin
          st_next = hard_reg ? dtef_pkg::ST_WAIT_SEC : dtef_pkg::ST_GAP4A;
          gate_next = !upd_reg;
          unr_next = 1'b0;
          sec_flag_next = 1'b0;
        end
      end
      default: begin
        if (byte_done) begin
          case (st_reg)
            dtef_pkg::ST_GAP4A: gap_last = mfm ? dtef_pkg::GAP4A_LAST_MFM : dtef_pkg::GAP4A_LAST_FM;
            dtef_pkg::ST_GAP1: gap_last = mfm ? dtef_pkg::GAP1_LAST_MFM : dtef_pkg::GAP1_LAST_FM;
            dtef_pkg::ST_GAP2: gap_last = mfm ? dtef_pkg::GAP2_LAST_MFM : dtef_pkg::GAP2_LAST_FM;
            dtef_pkg::ST_GAP3: gap_last = mfm ? dtef_pkg::GAP3_LAST_MFM : dtef_pkg::GAP3_LAST_FM;
            dtef_pkg::ST_SYNC_I, dtef_pkg::ST_SYNC_ID, dtef_pkg::ST_SYNC_D: gap_last = sync_last;
            dtef_pkg::ST_PRE_I, dtef_pkg::ST_PRE_ID, dtef_pkg::ST_PRE_D: gap_last = dtef_pkg::PRE_LAST;
            dtef_pkg::ST_IDB: gap_last = dtef_pkg::ID_LAST;
            dtef_pkg::ST_IDCRC, dtef_pkg::ST_DCRC: gap_last = dtef_pkg::CRC_LAST;
            dtef_pkg::ST_DATA: gap_last = 11'((dtef_pkg::DATA_BASE << id_reg.len_code) - 1'b1);
            default: gap_last = '0;
          endcase
          if (st_reg == dtef_pkg::ST_DATA) begin
            fifo_pop = fifo_valid;
            unr_next = unr_reg | !fifo_valid;
          end
          if (cnt_reg == gap_last) begin
            cnt_next = '0;
            case (st_reg)
              dtef_pkg::ST_GAP4A: st_next = dtef_pkg::ST_SYNC_I;
              dtef_pkg::ST_SYNC_I: st_next = mfm ? dtef_pkg::ST_PRE_I : dtef_pkg::ST_IAM;
              dtef_pkg::ST_PRE_I: st_next = dtef_pkg::ST_IAM;
              dtef_pkg::ST_IAM: st_next = dtef_pkg::ST_GAP1;
              dtef_pkg::ST_GAP1: st_next = dtef_pkg::ST_SYNC_ID;
              dtef_pkg::ST_WAIT_SEC: begin
                if (sec_flag_reg) begin
                  st_next = dtef_pkg::ST_SYNC_ID;
                  sec_flag_next = 1'b0;
                end
              end
              dtef_pkg::ST_SYNC_ID: st_next = mfm ? dtef_pkg::ST_PRE_ID : dtef_pkg::ST_IDAM;
              dtef_pkg::ST_PRE_ID: st_next = dtef_pkg::ST_IDAM;
              dtef_pkg::ST_IDAM: st_next = dtef_pkg::ST_IDB;
              dtef_pkg::ST_IDB: st_next = dtef_pkg::ST_IDCRC;
              dtef_pkg::ST_IDCRC: st_next = dtef_pkg::ST_GAP2;
              dtef_pkg::ST_GAP2: begin
                st_next = dtef_pkg::ST_SYNC_D;
                gate_next = 1'b1;
              end
              dtef_pkg::ST_SYNC_D: st_next = mfm ? dtef_pkg::ST_PRE_D : dtef_pkg::ST_DAM;
              dtef_pkg::ST_PRE_D: st_next = dtef_pkg::ST_DAM;
              dtef_pkg::ST_DAM: st_next = dtef_pkg::ST_DATA;
              dtef_pkg::ST_DATA: st_next = dtef_pkg::ST_DCRC;
              dtef_pkg::ST_DCRC: st_next = dtef_pkg::ST_WGOFF;
              dtef_pkg::ST_WGOFF: begin
                st_next = dtef_pkg::ST_GAP3;
                gate_next = !upd_reg;
              end
              dtef_pkg::ST_GAP3: begin
                id_next.record = 6'(id_reg.record + 1'b1);
                if (6'(id_reg.record + 1'b1) == recs_reg) begin
                  st_next = dtef_pkg::ST_GAP4B;
                end else begin
                  st_next = hard_reg ? dtef_pkg::ST_WAIT_SEC : dtef_pkg::ST_SYNC_ID;
                end
              end
              dtef_pkg::ST_GAP4B: begin
                if (idx_flag_reg) begin
                  st_next = dtef_pkg::ST_IDLE;
                  gate_next = 1'b0;
                end
              end
              default: st_next = dtef_pkg::ST_IDLE;
            endcase
          end
        end
      end
    endcase
    if (st_next == dtef_pkg::ST_IDLE || st_reg == dtef_pkg::ST_WAIT_IDX) begin
      idx_flag_next = 1'b0;
    end
    // A pulse in the clearing cycle still counts, except in ST_WAIT_IDX, where the edge starts the track
    idx_flag_next = idx_flag_next | (idx_edge && st_reg != dtef_pkg::ST_WAIT_IDX);
    sec_flag_next = sec_flag_next | sec_edge;
    busy_next = st_next != dtef_pkg::ST_IDLE;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      st_reg <= dtef_pkg::ST_IDLE;
      mode_reg <= dtef_pkg::DTEF_FM;
      id_reg <= '0;
      {cnt_reg, recs_reg, crc_reg, revs_reg} <= '0;
      {hard_reg, upd_reg, del_reg, gate_reg, ready_reg, ref_reg, unr_reg, idle_reg, busy_reg} <= '0;
      {idx_prev_reg, sec_prev_reg, idx_flag_reg, sec_flag_reg} <= '0;
    end else begin
      st_reg <= st_next;
      mode_reg <= mode_next;
      id_reg <= id_next;
      {cnt_reg, recs_reg, crc_reg, revs_reg} <= {cnt_next, recs_next, crc_next, revs_next};
      {hard_reg, upd_reg, del_reg, gate_reg} <= {hard_next, upd_next, del_next, gate_next};
      {ready_reg, ref_reg, unr_reg, idle_reg, busy_reg} <= {ready_next, ref_next, unr_next, idle_next, busy_next};
      {idx_prev_reg, sec_prev_reg, idx_flag_reg, sec_flag_reg} <= {index_i, sector_i, idx_flag_next, sec_flag_next};
    end
  end

  assign write_data_o = wd_reg;
  assign write_gate_o = gate_reg;
  assign side_o = id_reg.head;
  assign busy_o = busy_reg;
  assign ready_o = ready_reg;
  assign refused_o = ref_reg;
  assign underrun_o = unr_reg;
  assign idle_revs_o = idle_reg;
endmodule : dtef_formatter

// file: sim/dtef_chk.sv
`timescale 1ns/10ps
module dtef_chk (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic hard_sector_i,
  input wire logic [6:0] track_i,
  input wire logic [5:0] rec_count_i,
  input wire logic index_i,
  input wire logic write_data_o,
  input wire logic write_gate_o,
  input wire logic busy_o,
  input wire logic ready_o,
  input wire logic refused_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic bad_rec;
  assign bad_rec = hard_sector_i && (rec_count_i > dtef_pkg::MAX_HARD_RECORDS || rec_count_i == 6'h00);
  ////////////////////////////////////////////////////////////////////////////////
  property p_gate_pulse; write_data_o |-> write_gate_o; endproperty
  a_gate_pulse: assert property (p_gate_pulse) else $error("pulse with gate low");
  // Half cell is at least 250 cycles, so eight quiet cycles is a loose floor
  property p_pulse_gap; write_data_o |=> !write_data_o [*8]; endproperty
  a_pulse_gap: assert property (p_pulse_gap) else $error("pulses too close");
  property p_refuse_trk; start_i && !busy_o && track_i > dtef_pkg::MAX_TRACK |=> refused_o && !busy_o; endproperty
  a_refuse_trk: assert property (p_refuse_trk) else $error("bad track taken");
  property p_refuse_rec; start_i && !busy_o && bad_rec |=> refused_o && !busy_o; endproperty
  a_refuse_rec: assert property (p_refuse_rec) else $error("bad record count taken");
  property p_start_ok; start_i && !busy_o && track_i <= dtef_pkg::MAX_TRACK && !bad_rec |=> busy_o && !refused_o;
  endproperty
  a_start_ok: assert property (p_start_ok) else $error("good start not taken");
  property p_idle_gate; !busy_o |-> !write_gate_o; endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("gate while idle");
  property p_ready_set; $rose(index_i) |-> ##[1:3] ready_o; endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set by index");
  property p_ready_hold; ready_o |=> ready_o; endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
endmodule : dtef_chk

bind dtef_formatter dtef_chk u_chk (.*);

// file: sim/dtef_drive_model.sv
`timescale 1ns/10ps
module dtef_drive_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic write_data_i,
  input wire logic write_gate_i,
  input wire logic [9:0] half_i,
  output logic index_o,
  output logic sector_o,
  output logic [47:0] slots_o
);
  int cnt = 0;
  int s;
  initial index_o = 1'b0;
  initial sector_o = 1'b0;
  // Slots rounded to nearest so a pulse late in its slot still lands right
  always @(posedge sys_clk_i) begin
    if (!nrst_i || !write_gate_i) begin
      cnt <= 0;
      if (!nrst_i) slots_o <= '0;
    end else begin
      cnt <= cnt + 1;
      s = (cnt + half_i / 2) / half_i - 1;
      if (write_data_i && s >= 0 && s < 48) slots_o[47 - s] <= 1'b1;
    end
  end
  // One revolution mark; width shortened
  task rev;
    @(posedge sys_clk_i) index_o <= 1'b1;
    // Sector pulse rides with index so a hard track opens its first record after one fill byte
    sector_o <= 1'b1;
    repeat (50) @(posedge sys_clk_i);
    index_o <= 1'b0;
    sector_o <= 1'b0;
  endtask : rev
endmodule : dtef_drive_model

// file: sim/dtef_formatter_tb_top.sv
`timescale 1ns/10ps
module dtef_formatter_tb_top;
  logic sys_clk_i = 0, nrst_i = 0, hard_sector_i = 0, update_i = 0, deleted_i = 0, start_i = 0;
  logic side_i = 0, din_valid_i = 0, index_i, sector_i, din_ready_o, write_data_o, write_gate_o;
  logic side_o, busy_o, ready_o, refused_o, underrun_o, idle_revs_o;
  dtef_pkg::dtef_mode_t mode_i = dtef_pkg::DTEF_FM;
  logic [6:0] track_i = '0;
  logic [5:0] rec_count_i = 6'h01;
  logic [1:0] len_code_i = '0;
  logic [7:0] din_data_i = '0;
  logic [47:0] slots;
  logic [9:0] half = 10'(dtef_pkg::FM_HALF_CELL);
  int err_count = 0, n_compared = 0, cyc = 0;
  initial forever #2 sys_clk_i = ~sys_clk_i;
  dtef_formatter DUT (.*);
  dtef_drive_model u_drv (.sys_clk_i, .nrst_i, .write_data_i(write_data_o), .write_gate_i(write_gate_o),
    .half_i(half), .index_o(index_i), .sector_o(sector_i), .slots_o(slots));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task close_out;
    $display("compared=%0d mismatches=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      close_out();
    end
  end
  function automatic logic [47:0] enc3(input logic [1:0] m, input logic [23:0] b);
    logic [47:0] r;
    logic pd, pc, c, d;
    r = '0;
    pd = 0;
    pc = 0;
    for (int k = 0; k < 24; k++) begin
      d = b[23 - k];
      c = (m == 2'b00) ? 1'b1 : (m == 2'b01) ? (!pd && !d) : (!pd && !pc && !d);
      r = {r[45:0], c, d};
      pd = d;
      pc = c;
    end
    return r;
  endfunction : enc3
  task do_reset;
    @(posedge sys_clk_i) nrst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : do_reset
  task start_trk(input dtef_pkg::dtef_mode_t m, input logic [6:0] t, input logic h, input logic [5:0] r);
    @(posedge sys_clk_i);
    mode_i <= m;
    track_i <= t;
    hard_sector_i <= h;
    rec_count_i <= r;
    side_i <= 1'($urandom);
    deleted_i <= 1'($urandom);
    len_code_i <= 2'($urandom);
    start_i <= 1'b1;
    @(posedge sys_clk_i) start_i <= 1'b0;
    #1;
  endtask : start_trk
  // Leading clock of the first cell depends on what preceded the gate, so it is masked
  task run_mode(input dtef_pkg::dtef_mode_t m, input logic h, input logic [23:0] bytes);
    half <= (m == dtef_pkg::DTEF_FM) ? 10'(dtef_pkg::FM_HALF_CELL) : 10'(dtef_pkg::MFM_HALF_CELL);
    do_reset();
    start_trk(m, 7'($urandom % 77), h, 6'(1 + $urandom % 32));
    chk(busy_o, 1'b1);
    chk(write_gate_o, 1'b0);
    u_drv.rev();
    for (int i = 0; i < 10 && write_gate_o !== 1'b1; i++) @(posedge sys_clk_i);
    #1;
    chk(write_gate_o, 1'b1);
    chk(side_o, side_i);
    repeat (49 * half) @(posedge sys_clk_i);
    #1;
    chk(slots & 48'h7FFFFFFFFFFF, enc3(m, bytes) & 48'h7FFFFFFFFFFF);
  endtask : run_mode
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h2a15310a));
    do_reset();
    chk({din_ready_o, busy_o, ready_o, underrun_o, idle_revs_o}, 5'h10);
    start_trk(dtef_pkg::DTEF_FM, 7'h4D, 1'b0, 6'h01);
    chk({refused_o, busy_o}, 2'h2);
    start_trk(dtef_pkg::DTEF_MFM, 7'h05, 1'b1, 6'h21);
    chk({refused_o, busy_o}, 2'h2);
    start_trk(dtef_pkg::DTEF_MFM, 7'h05, 1'b1, 6'h00);
    chk({refused_o, busy_o}, 2'h2);
    repeat (14) u_drv.rev();
    #1;
    chk(idle_revs_o, 1'b0);
    u_drv.rev();
    #1;
    chk(idle_revs_o, 1'b1);
    start_trk(dtef_pkg::DTEF_MFM, 7'h4C, 1'b1, 6'h20);
    chk({refused_o, busy_o}, 2'h1);
    start_trk(dtef_pkg::DTEF_FM, 7'h7F, 1'b0, 6'h01);
    chk({refused_o, busy_o}, 2'h1);
    u_drv.rev();
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(ready_o, 1'b1);
    // Twenty offers, only sixteen fit
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk_i);
      din_valid_i <= 1'b1;
      din_data_i <= 8'($urandom);
    end
    @(posedge sys_clk_i) din_valid_i <= 1'b0;
    #1;
    chk(din_ready_o, 1'b0);
    run_mode(dtef_pkg::DTEF_FM, 1'b0, {3{dtef_pkg::FILL_FM}});
    run_mode(dtef_pkg::DTEF_MFM, 1'b0, {3{dtef_pkg::FILL_MFM}});
    run_mode(dtef_pkg::DTEF_M2FM, 1'b1, {dtef_pkg::FILL_MFM, dtef_pkg::BYTE_SYNC, dtef_pkg::BYTE_SYNC});
    // Update write keeps the gate down through the index and ID part
    update_i <= 1'b1;
    do_reset();
    start_trk(dtef_pkg::DTEF_MFM, 7'h00, 1'b0, 6'h01);
    u_drv.rev();
    #1;
    chk(write_gate_o, 1'b0);
    close_out();
  end
endmodule : dtef_formatter_tb_top
